// >>> logic/lcd_vram_access_command_port.sv
// Host command port: cursor address, display memory access, bit ops, busy.
// Assumes host pins are asynchronous to ref_clk and strobes are slow.
`timescale 1ns/1ps

module lcd_vram_access_command_port #(
	parameter int DCLK_DIV = lcd_cmd_pkg::DCLK_DIV_DEFAULT,
	parameter int FIFO_DEPTH = lcd_cmd_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Host bus pins
	input wire logic bus_enable,
	input wire logic register_select,
	input wire logic read_not_write,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_n,
	// Status
	output logic busy_indicator,
	output logic graphics_mode,
	output logic [lcd_cmd_pkg::ADDR_W-1:0] cursor_address
);

	import lcd_cmd_pkg::*;

	// ====================================================================
	// Declarations
	logic e_s1;
	logic e_s2;
	logic e_s3;
	logic rs_s1;
	logic rs_s2;
	logic rnw_s1;
	logic rnw_s2;
	logic [7:0] d_s1;
	logic [7:0] d_s2;
	logic e_fall;
	logic status_read;
	logic push_valid;
	logic push_ready;
	logic push_data;
	logic [ENT_W-1:0] push_entry;
	logic pop_valid;
	logic pop_ready;
	logic [ENT_W-1:0] pop_entry;
	logic pop;
	logic pop_instr;
	logic pop_data_rd;
	logic pop_data_wr;
	logic [7:0] pop_byte;
	logic op_rd;
	logic op_wr;
	logic op_bit;
	logic op_setup;
	logic op_mem;
	logic dclk_tick;
	logic [7:0] mem [2**ADDR_W];
	logic [ADDR_W-1:0] eff_addr;
	logic [7:0] bit_mask;
	logic [7:0] bit_result;
	logic [2:0] h_pitch_m1;
	logic [4:0] bit_pulses;
	eng_state_t state_reg;
	logic [4:0] wait_reg;
	logic pending_reg;
	logic [7:0] instr_reg;
	logic [7:0] mode_reg;
	logic [7:0] pitch_reg;
	logic [ADDR_W-1:0] cursor_reg;
	logic [7:0] rd_latch_reg;
	logic busy_reg;

	// ====================================================================
	// Pin synchronisers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			e_s1 <= 1'b0;
			e_s2 <= 1'b0;
			e_s3 <= 1'b0;
			rs_s1 <= 1'b0;
			rs_s2 <= 1'b0;
			rnw_s1 <= 1'b0;
			rnw_s2 <= 1'b0;
			d_s1 <= 8'h00;
			d_s2 <= 8'h00;
		end else begin
			e_s1 <= bus_enable;
			e_s2 <= e_s1;
			e_s3 <= e_s2;
			rs_s1 <= register_select;
			rs_s2 <= rs_s1;
			rnw_s1 <= read_not_write;
			rnw_s2 <= rnw_s1;
			d_s1 <= data_in;
			d_s2 <= d_s1;
		end
	end

	// ====================================================================
	// Host transfer capture
	// A transfer counts at the falling strobe; status reads queue nothing.
	assign e_fall = e_s3 && !e_s2;
	assign status_read = rs_s2 && rnw_s2;
	assign push_data = !rs_s2;
	// Instruction writes bypass the busy gate so they never wait
	assign push_valid = e_fall && !status_read
		&& (rs_s2 || !busy_reg);
	assign push_entry = {rnw_s2, rs_s2, d_s2};

	cmd_fifo #(
		.W(ENT_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.rst(rst),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_entry),
		.out_valid(pop_valid),
		.out_ready(pop_ready),
		.out_data(pop_entry)
	);

	dclk_divider #(
		.DIV(DCLK_DIV)
	) u_div (
		.ref_clk(ref_clk),
		.rst(rst),
		.tick(dclk_tick)
	);

	// ====================================================================
	// Command decode
	assign pop_ready = state_reg == S_IDLE;
	assign pop = pop_valid && pop_ready;
	assign pop_byte = pop_entry[7:0];
	assign pop_instr = pop && pop_entry[ENT_RS];
	assign pop_data_rd = pop && !pop_entry[ENT_RS] && pop_entry[ENT_RNW];
	assign pop_data_wr = pop && !pop_entry[ENT_RS] && !pop_entry[ENT_RNW];
	assign op_rd = pop_data_rd && instr_reg == CODE_VRAM_RD;
	assign op_wr = pop_data_wr && instr_reg == CODE_VRAM_WR;
	assign op_bit = pop_data_wr && (instr_reg == CODE_BIT_CLR
		|| instr_reg == CODE_BIT_SET);
	assign op_setup = pop_data_wr && !op_wr && !op_bit;
	assign op_mem = op_rd || op_wr || op_bit;

	// Character mode drops the upper nibble of the high byte
	assign eff_addr = mode_reg[MODE_GRAPHICS_BIT] ? cursor_reg
		: (cursor_reg & CHAR_ADDR_MASK);
	assign bit_mask = BIT_ONE << pop_byte[2:0];
	assign bit_result = (instr_reg == CODE_BIT_SET)
		? (mem[eff_addr] | bit_mask)
		: (mem[eff_addr] & ~bit_mask);
	assign h_pitch_m1 = pitch_reg[2:0];
	assign bit_pulses = BUSY_BIT_EXTRA + {2'b00, h_pitch_m1} + 5'h01;

	// ====================================================================
	// Display memory
	// Bytes are stored as given; bit 0 goes to the leftmost dot.
	always_ff @(posedge ref_clk) begin
		if (op_wr) begin
			mem[eff_addr] <= pop_byte;
		end else if (op_bit) begin
			mem[eff_addr] <= bit_result;
		end
	end

	// Read latch: each read shows the byte fetched by the one before
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_latch_reg <= 8'h00;
		end else if (op_rd) begin
			rd_latch_reg <= mem[eff_addr];
		end
	end

	// ====================================================================
	// Instruction and setup registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			instr_reg <= INSTR_RESET;
		end else if (pop_instr) begin
			instr_reg <= pop_byte;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode_reg <= MODE_RESET;
			pitch_reg <= PITCH_RESET;
		end else if (op_setup) begin
			if (instr_reg == CODE_MODE) begin
				mode_reg <= pop_byte;
			end
			if (instr_reg == CODE_PITCH) begin
				pitch_reg <= pop_byte;
			end
		end
	end

	// ====================================================================
	// Cursor address
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cursor_reg <= '0;
		end else if (op_setup && instr_reg == CODE_CUR_LO) begin
			cursor_reg[7:0] <= pop_byte;
		end else if (op_setup && instr_reg == CODE_CUR_HI) begin
			cursor_reg[15:8] <= pop_byte;
		end else if (op_mem) begin
			cursor_reg <= eff_addr + CURSOR_STEP;
		end
	end

	// ====================================================================
	// Busy timing
	// Waits count whole enable pulses, so the first period is partial;
	// one extra pulse keeps every wait above its least figure.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= S_IDLE;
			wait_reg <= 5'h00;
		end else begin
			unique case (state_reg)
				S_IDLE: begin
					if (op_bit) begin
						state_reg <= S_WAIT;
						wait_reg <= bit_pulses;
					end else if (op_rd || op_wr) begin
						state_reg <= S_WAIT;
						wait_reg <= BUSY_VRAM_PULSES;
					end else if (op_setup || pop_data_rd) begin
						state_reg <= S_WAIT;
						wait_reg <= BUSY_SETUP_PULSES;
					end
				end
				S_WAIT: begin
					if (dclk_tick) begin
						if (wait_reg == 5'h01) begin
							state_reg <= S_IDLE;
						end
						wait_reg <= wait_reg - 5'h01;
					end
				end
			endcase
		end
	end

	// A data transfer stays pending from capture until its pop
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pending_reg <= 1'b0;
		end else if (push_valid && push_ready && push_data) begin
			pending_reg <= 1'b1;
		end else if (pop_data_rd || pop_data_wr) begin
			pending_reg <= 1'b0;
		end
	end

	// Instructions alone mark the port busy only by filling the FIFO
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= pending_reg || state_reg == S_WAIT
				|| (push_valid && push_data) || !push_ready;
		end
	end

	// ====================================================================
	// Host read path and status outputs
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			data_out <= 8'h00;
			data_oe_n <= 1'b1;
			busy_indicator <= 1'b0;
			graphics_mode <= 1'b0;
			cursor_address <= '0;
		end else begin
			if (rs_s2) begin
				data_out <= {busy_reg, STATUS_PAD};
			end else begin
				data_out <= rd_latch_reg;
			end
			data_oe_n <= !(e_s2 && rnw_s2);
			busy_indicator <= busy_reg;
			graphics_mode <= mode_reg[MODE_GRAPHICS_BIT];
			cursor_address <= eff_addr;
		end
	end

endmodule : lcd_vram_access_command_port

// >>> logic/lcd_cmd_pkg.sv
// Constants for the display-memory access command port.
// Assumes one 25 MHz clock and a host on an 8-bit parallel strobe bus.

package lcd_cmd_pkg;

	// ====================================================================
	// Instruction codes
	localparam logic [7:0] CODE_MODE = 8'h00;
	localparam logic [7:0] CODE_PITCH = 8'h01;
	localparam logic [7:0] CODE_CUR_LO = 8'h0A;
	localparam logic [7:0] CODE_CUR_HI = 8'h0B;
	localparam logic [7:0] CODE_VRAM_WR = 8'h0C;
	localparam logic [7:0] CODE_VRAM_RD = 8'h0D;
	localparam logic [7:0] CODE_BIT_CLR = 8'h0E;
	localparam logic [7:0] CODE_BIT_SET = 8'h0F;

	// ====================================================================
	// Fields and reset values
	localparam int MODE_GRAPHICS_BIT = 1;
	localparam int BUSY_BIT = 7;
	localparam int ADDR_W = 16;
	localparam logic [15:0] CHAR_ADDR_MASK = 16'h0FFF;
	localparam logic [15:0] CURSOR_STEP = 16'h0001;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] PITCH_RESET = 8'h07;
	localparam logic [7:0] INSTR_RESET = 8'h00;
	localparam logic [7:0] BIT_ONE = 8'h01;
	localparam logic [6:0] STATUS_PAD = 7'h00;

	// ====================================================================
	// FIFO entry layout: {read_not_write, register_select, byte}
	localparam int ENT_W = 10;
	localparam int ENT_RNW = 9;
	localparam int ENT_RS = 8;
	localparam int FIFO_DEPTH = 16;

	// ====================================================================
	// Timing; busy waits counted in display clock enable pulses
	localparam int REF_CLK_NS = 40;
	localparam int INSTR_MAX_NS = 1000;
	localparam int INSTR_MAX_CYCLES = INSTR_MAX_NS / REF_CLK_NS;
	localparam int DCLK_DIV_DEFAULT = 50;
	localparam logic [4:0] BUSY_SETUP_PULSES = 5'h02;
	localparam logic [4:0] BUSY_VRAM_PULSES = 5'h03;
	localparam logic [4:0] BUSY_BIT_EXTRA = 5'h03;

	typedef enum logic {S_IDLE, S_WAIT} eng_state_t;

endpackage : lcd_cmd_pkg

// >>> logic/dclk_divider.sv
// Display clock enable divider.
// Assumes a single reference clock; emits one-cycle enable pulses.
`timescale 1ns/1ps

module dclk_divider #(
	parameter int DIV = 50
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Enable out
	output logic tick
);

	logic [15:0] count_reg;

	// ====================================================================
	// Counter
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count_reg <= 16'h0000;
			tick <= 1'b0;
		end else if (count_reg == 16'(DIV - 1)) begin
			count_reg <= 16'h0000;
			tick <= 1'b1;
		end else begin
			count_reg <= count_reg + 16'h0001;
			tick <= 1'b0;
		end
	end

endmodule : dclk_divider

// >>> logic/cmd_fifo.sv
// Synchronous FIFO for host transfers.
// Assumes both sides on ref_clk; valid/ready handshake on each side.
`timescale 1ns/1ps

module cmd_fifo #(
	parameter int W = 10,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic do_wr;
	logic do_rd;

	// ====================================================================
	// Flags
	assign in_ready = (wr_ptr_reg[AW] == rd_ptr_reg[AW])
		|| (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
	assign out_valid = wr_ptr_reg != rd_ptr_reg;
	assign out_data = mem[rd_ptr_reg[AW-1:0]];
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;

	// ====================================================================
	// Storage and pointers
	always_ff @(posedge ref_clk) begin
		if (do_wr) begin
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end

endmodule : cmd_fifo

// >>> sim/lcd_cmd_monitor.sv
// Checker for the command port, bound to its top module.
// Assumes one clock and a host holding strobes four cycles.
`timescale 1ns/1ps

module lcd_cmd_monitor #(
	parameter int DCLK_DIV = 50
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Host bus
	input wire logic bus_enable,
	input wire logic register_select,
	input wire logic read_not_write,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic data_oe_n,
	// Status
	input wire logic busy_indicator,
	input wire logic graphics_mode,
	input wire logic [lcd_cmd_pkg::ADDR_W-1:0] cursor_address
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ====================
	// Strobe fall age, busy length
	logic en_d;
	logic rs_fall;
	int unsigned since_fall;
	int unsigned busy_run;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			en_d <= 1'b0;
			rs_fall <= 1'b0;
			since_fall <= 0;
		end else begin
			en_d <= bus_enable;
			if (en_d && !bus_enable) begin
				rs_fall <= register_select;
				since_fall <= 0;
			end else if (since_fall < 1000)
				since_fall <= since_fall + 1;
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			busy_run <= 0;
		else
			busy_run <= busy_indicator ? busy_run + 1 : 0;
	end

	// ====================
	// Properties
	a_busy_cause: assert property ($rose(busy_indicator) |->
		since_fall <= 8 && !rs_fall) else $error("busy without data");
	a_busy_max: assert property (busy_run <= 18*DCLK_DIV+8)
		else $error("busy too long");
	a_busy_min: assert property ($fell(busy_indicator) |->
		busy_run >= DCLK_DIV) else $error("busy too short");
	a_status_pad: assert property (register_select &&
		$past(register_select, 4) && !data_oe_n |->
		data_out[6:0] == 7'h00) else $error("status pad");
	a_status_busy: assert property (register_select &&
		$past(register_select, 4) && !data_oe_n |->
		data_out[7] == busy_indicator ||
		data_out[7] == $past(busy_indicator)) else $error("status bit");
	a_write_quiet: assert property (!read_not_write [*5] |->
		data_oe_n) else $error("drive on write");
	a_idle_quiet: assert property (!bus_enable [*5] |->
		data_oe_n) else $error("drive when idle");
	a_char_mask: assert property (!graphics_mode &&
		$past(graphics_mode) == 1'b0 |-> cursor_address[15:12] == 4'h0)
		else $error("char mode address");
	a_cursor_cause: assert property ($changed(cursor_address) |->
		##[0:4] busy_indicator) else $error("cursor moved idle");
	a_mode_cause: assert property ($changed(graphics_mode) |->
		##[0:4] busy_indicator) else $error("mode moved idle");

	c_busy: cover property ($rose(busy_indicator));
	c_status: cover property (register_select && !data_oe_n);
	c_gfx: cover property ($rose(graphics_mode));
endmodule : lcd_cmd_monitor

bind lcd_vram_access_command_port lcd_cmd_monitor #(
	.DCLK_DIV(DCLK_DIV)
) u_lcd_cmd_monitor (
	.ref_clk(ref_clk), .rst(rst), .bus_enable(bus_enable),
	.register_select(register_select), .read_not_write(read_not_write),
	.data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
	.busy_indicator(busy_indicator), .graphics_mode(graphics_mode),
	.cursor_address(cursor_address)
);

// >>> sim/host_model.sv
// Host model: 8-bit microprocessor on the strobe bus.
// Assumes ref_clk paces it; the bench calls its tasks.
`timescale 1ns/1ps

module host_model (
	// Clock
	input wire logic ref_clk,
	// Pins to the port
	output logic bus_enable,
	output logic register_select,
	output logic read_not_write,
	output logic [7:0] data_in,
	// Pins from the port
	input wire logic [7:0] data_out,
	input wire logic data_oe_n
);
	import lcd_cmd_pkg::*;
	initial begin
		bus_enable = 1'b0;
		register_select = 1'b1;
		read_not_write = 1'b0;
		data_in = 8'h00;
	end

	// ====================
	// Strobe high 5, low 5: above the 4-cycle minimum
	task automatic xfer(input logic rs, input logic rnw,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge ref_clk);
		#1;
		register_select = rs;
		read_not_write = rnw;
		data_in = rnw ? ~data_in : d;
		bus_enable = 1'b1;
		repeat (5) @(posedge ref_clk);
		#1;
		q = data_oe_n ? 8'hXX : data_out;
		// Data holds past the strobe fall; the port samples it late
		bus_enable = 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask : xfer

	task automatic poll();
		logic [7:0] s;
		s = 8'h80;
		for (int i = 0; i < 300 && s[7] !== 1'b0; i++)
			xfer(1'b1, 1'b1, 8'h00, s);
	endtask : poll

	task automatic instr(input logic [7:0] c);
		logic [7:0] q;
		xfer(1'b1, 1'b0, c, q);
	endtask : instr

	task automatic data(input logic [7:0] d);
		logic [7:0] q;
		poll();
		xfer(1'b0, 1'b0, d, q);
	endtask : data

	task automatic rd(output logic [7:0] q);
		poll();
		xfer(1'b0, 1'b1, 8'h00, q);
	endtask : rd

	task automatic cmd(input logic [7:0] c, input logic [7:0] d);
		instr(c);
		data(d);
		poll();
	endtask : cmd

	// Low byte first, high byte right after
	task automatic set_cursor(input logic [15:0] a);
		cmd(CODE_CUR_LO, a[7:0]);
		cmd(CODE_CUR_HI, a[15:8]);
	endtask : set_cursor
endmodule : host_model

// >>> sim/lcd_vram_access_command_port_tb.sv
// Bench for the command port: host model and scenarios.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
	total_checks++; \
	if ((s) !== (e)) begin \
		err_total++; \
		$display("[ERR] %s exp %h got %h", n, e, s); \
	end \
end

module lcd_vram_access_command_port_tb;
	import lcd_cmd_pkg::*;
	localparam int DIV = 16;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic bus_enable;
	logic register_select;
	logic read_not_write;
	logic [7:0] data_in;
	logic [7:0] data_out;
	logic data_oe_n;
	logic busy_indicator;
	logic graphics_mode;
	logic [15:0] cursor_address;
	logic [7:0] q;
	int err_total = 0;
	int total_checks = 0;
	int run = 0;
	int last = 0;

	always #20 ref_clk = ~ref_clk;
	// Length of the latest busy pulse
	always @(posedge ref_clk) begin
		if (busy_indicator === 1'b1)
			run <= run + 1;
		else if (run != 0) begin
			last <= run;
			run <= 0;
		end
	end

	lcd_vram_access_command_port #(
		.DCLK_DIV(DIV)
	) u_lcd_vram_access_command_port (
		.ref_clk(ref_clk), .rst(rst), .bus_enable(bus_enable),
		.register_select(register_select), .read_not_write(read_not_write),
		.data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
		.busy_indicator(busy_indicator), .graphics_mode(graphics_mode),
		.cursor_address(cursor_address)
	);
	host_model u_host_model (
		.ref_clk(ref_clk), .bus_enable(bus_enable),
		.register_select(register_select), .read_not_write(read_not_write),
		.data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n)
	);

	// ====================
	// Scenarios
	task automatic t_write_read();
		u_host_model.set_cursor(16'h01FF);
		`CHK("cursor", 16'h01FF, cursor_address);
		u_host_model.instr(CODE_VRAM_WR);
		for (int i = 0; i < 4; i++)
			u_host_model.data(8'h40 + 8'(i));
		u_host_model.poll();
		`CHK("cursor", 16'h0203, cursor_address);
		`CHK("vram", 1'b1, last >= 2*DIV && last <= 10*DIV+4);
		u_host_model.set_cursor(16'h01FF);
		u_host_model.instr(CODE_VRAM_RD);
		u_host_model.rd(q);
		for (int i = 0; i < 4; i++) begin
			u_host_model.rd(q);
			`CHK("rd", 8'h40 + 8'(i), q);
		end
	endtask : t_write_read

	task automatic t_bits();
		logic [7:0] e;
		u_host_model.set_cursor(16'h0300);
		u_host_model.instr(CODE_VRAM_WR);
		for (int k = 0; k < 16; k++)
			u_host_model.data(k < 8 ? 8'h00 : 8'hFF);
		u_host_model.set_cursor(16'h0300);
		for (int k = 0; k < 16; k++)
			u_host_model.cmd(k < 8 ? CODE_BIT_SET : CODE_BIT_CLR,
				8'(k % 8));
		`CHK("bitop", 1'b1, last >= 10*DIV && last <= 18*DIV+4);
		`CHK("cursor", 16'h0310, cursor_address);
		u_host_model.set_cursor(16'h0300);
		u_host_model.instr(CODE_VRAM_RD);
		u_host_model.rd(q);
		for (int k = 0; k < 16; k++) begin
			e = 8'h01 << (k % 8);
			u_host_model.rd(q);
			`CHK("bit", k < 8 ? e : ~e, q);
		end
	endtask : t_bits

	task automatic t_busy();
		u_host_model.set_cursor(16'h0500);
		u_host_model.instr(CODE_VRAM_WR);
		`CHK("busy", 1'b0, busy_indicator);
		u_host_model.xfer(1'b0, 1'b0, 8'hAA, q);
		u_host_model.xfer(1'b1, 1'b1, 8'h00, q);
		`CHK("status", 8'h80, q);
		u_host_model.xfer(1'b0, 1'b0, 8'hBB, q);
		u_host_model.poll();
		`CHK("cursor", 16'h0501, cursor_address);
		u_host_model.xfer(1'b1, 1'b1, 8'h00, q);
		`CHK("status", 8'h00, q);
		u_host_model.set_cursor(16'h0500);
		u_host_model.instr(CODE_VRAM_RD);
		u_host_model.rd(q);
		u_host_model.rd(q);
		`CHK("rd", 8'hAA, q);
	endtask : t_busy

	task automatic t_graphics();
		`CHK("gfx", 1'b0, graphics_mode);
		u_host_model.cmd(CODE_MODE, 8'h02);
		`CHK("gfx", 1'b1, graphics_mode);
		`CHK("setup", 1'b1, last >= DIV && last <= 2*DIV+4);
		u_host_model.set_cursor(16'hABCD);
		`CHK("cursor", 16'hABCD, cursor_address);
		u_host_model.cmd(CODE_VRAM_WR, 8'h5A);
		`CHK("cursor", 16'hABCE, cursor_address);
		u_host_model.cmd(CODE_MODE, 8'h00);
		`CHK("cursor", 16'h0BCE, cursor_address);
	endtask : t_graphics

	task automatic t_reset();
		u_host_model.cmd(CODE_MODE, 8'h02);
		`CHK("gfx", 1'b1, graphics_mode);
		@(posedge ref_clk);
		#1;
		rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK("rst gfx", 1'b0, graphics_mode);
		`CHK("rst cursor", 16'h0000, cursor_address);
		`CHK("rst busy", 1'b0, busy_indicator);
		rst = 1'b0;
		u_host_model.set_cursor(16'h0123);
		`CHK("cursor", 16'h0123, cursor_address);
	endtask : t_reset

	task automatic stop_test();
		if (err_total == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	initial begin
		#4000000;
		err_total++;
		stop_test();
	end

	initial begin
		repeat (8) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		t_write_read();
		t_bits();
		t_busy();
		t_graphics();
		t_reset();
		stop_test();
	end
endmodule : lcd_vram_access_command_port_tb
